/* File: design/rtcpw_pkg.sv */
// package: register map, field positions and types for the calendar window front end
package rtcpw_pkg;
    // register byte offsets on the axi4-lite bus
    localparam logic [4:0] rtcpw_off_clk_cfg = 5'h00;
    localparam logic [4:0] rtcpw_off_alm_cfg = 5'h04;
    localparam logic [4:0] rtcpw_off_time_win = 5'h08;
    localparam logic [4:0] rtcpw_off_alm_win = 5'h0c;
    localparam logic [4:0] rtcpw_off_unlock = 5'h10;
    localparam logic [4:0] rtcpw_off_pad_cfg = 5'h14;
    // field positions
    localparam int rtcpw_ptr_lsb = 8;
    localparam int rtcpw_oe_bit = 10;
    localparam int rtcpw_wren_bit = 13;
    localparam int rtcpw_sel_bit = 1;
    localparam int rtcpw_ttl_bit = 0;
    // reset values
    localparam logic [15:0] rtcpw_clk_cfg_rst = 16'h0000;
    localparam logic [15:0] rtcpw_alm_cfg_rst = 16'h0000;
    localparam logic [1:0] rtcpw_pad_cfg_rst = 2'h0;
    localparam logic [15:0] rtcpw_cal_rst = 16'h0000;
    // unlock key values
    localparam logic [7:0] rtcpw_key_first = 8'h55;
    localparam logic [7:0] rtcpw_key_second = 8'haa;
    // cycles the unlock stays open after the second key
    localparam logic [1:0] rtcpw_unlock_cycles = 2'h1;
    localparam logic [1:0] rtcpw_ptr_min = 2'h0;
    localparam logic [1:0] rtcpw_axi_okay = 2'h0;
    localparam logic [1:0] rtcpw_axi_slverr = 2'h2;

    // one bus access seen by a window
    typedef struct packed {
        logic rd;
        logic wr_lo;
        logic wr_hi;
        logic [15:0] wdata;
    } rtcpw_acc_t;
endpackage : rtcpw_pkg

/* File: design/rtcpw_unlock.sv */
// unlock key sequencer: opens a one-cycle window after 55h then aah
`timescale 1ns/1ns
`default_nettype none
module rtcpw_unlock (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // key writes
    input wire logic key_wr,
    input wire logic [7:0] key_data,
    // unlock window open
    output logic open_o
);
    import rtcpw_pkg::*;
    typedef enum logic [1:0] {rtcpw_idle, rtcpw_got55, rtcpw_open} rtcpw_ukst_t;
    rtcpw_ukst_t st_r;
    rtcpw_ukst_t st_nxt;

    always_comb begin
        st_nxt = rtcpw_idle;
        case (st_r)
            rtcpw_idle: begin
                if (key_wr && key_data == rtcpw_key_first) st_nxt = rtcpw_got55;
            end
            rtcpw_got55: begin
                if (key_wr && key_data == rtcpw_key_second) st_nxt = rtcpw_open;
                else if (key_wr && key_data == rtcpw_key_first) st_nxt = rtcpw_got55;
                else if (!key_wr) st_nxt = rtcpw_got55;
            end
            // open for exactly one cycle, any other access closes it
            default: begin
                if (key_wr && key_data == rtcpw_key_first) st_nxt = rtcpw_got55;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) st_r <= rtcpw_idle;
        else st_r <= st_nxt;
    end

    assign open_o = (st_r == rtcpw_open);

    open_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
        open_o |=> !open_o) else $error("unlock window longer than one cycle");
    open_cause_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(open_o) |-> $past(key_wr) && $past(key_data) == rtcpw_key_second)
        else $error("unlock opened without second key");
endmodule : rtcpw_unlock
`default_nettype wire

/* File: design/rtcpw_window.sv */
// one pointer window: 2-bit auto-decrementing pointer over register pairs
`timescale 1ns/1ns
`default_nettype none
module rtcpw_window #(
    parameter int NPAIR = 4
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // pointer load from config register
    input wire logic ptr_ld,
    input wire logic [1:0] ptr_ld_val,
    // window access
    input wire rtcpw_pkg::rtcpw_acc_t acc,
    input wire logic wr_allow,
    // state
    output logic [1:0] ptr_o,
    output logic [15:0] rdata_o
);
    import rtcpw_pkg::*;
    logic [7:0] hi_r [NPAIR];
    logic [7:0] lo_r [NPAIR];
    logic [1:0] ptr_r;
    logic dec;
    logic hi_used;

    // pointer walks down and sticks at zero; reads and high-byte writes step it
    assign dec = acc.rd || acc.wr_hi;
    // pair 3 high byte is unused in either window
    assign hi_used = (ptr_r != 2'h3);
    assign rdata_o = {hi_used ? hi_r[ptr_r] : 8'h00, lo_r[ptr_r]};
    assign ptr_o = ptr_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) ptr_r <= rtcpw_ptr_min;
        else if (ptr_ld) ptr_r <= ptr_ld_val;
        else if (dec && ptr_r != rtcpw_ptr_min) ptr_r <= ptr_r - 2'h1;
    end

    // storage for each pair; writes land at the pointer before it steps
    for (genvar i = 0; i < NPAIR; i++) begin : g_pair
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                hi_r[i] <= 8'h00;
                lo_r[i] <= 8'h00;
            end else if (wr_allow && ptr_r == 2'(i)) begin
                if (acc.wr_hi && i != 3) hi_r[i] <= acc.wdata[15:8];
                if (acc.wr_lo) lo_r[i] <= acc.wdata[7:0];
            end
        end
    end

    ptr_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!ptr_ld && dec && ptr_r != 2'h0) |=> ptr_r == $past(ptr_r) - 2'h1)
        else $error("pointer did not step down");
    ptr_floor_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!ptr_ld && ptr_r == 2'h0) |=> ptr_r == 2'h0) else $error("pointer left zero by itself");
    lo_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!ptr_ld && acc.wr_lo && !acc.wr_hi && !acc.rd) |=> $stable(ptr_r))
        else $error("low byte write moved pointer");
endmodule : rtcpw_window
`default_nettype wire

/* File: design/rtcpw_top.sv */
// calendar register window front end with axi4-lite slave
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - time pointer bits 9:8 select time pair
// - time pairs: minsec, wdayhour, monthday, year
// - time high write decrements pointer, stops 00
// - at 00 stays on minutes/seconds
// - alarm pointer bits 9:8 select alarm pair
// - alarm pairs: minsec, wdayhour, monthday, none
// - alarm high write decrements pointer, stops 00
// - alarm at 00 stays until reloaded
// - alarm window read decrements alarm pointer
// - time window read decrements time pointer
// - any read width decrements exactly once
// - low byte writes leave pointer unchanged
// - select bit: seconds clock or alarm pulse
// - pin driven only with output enable
// - time writes need value-write enable set
// - enable settable only right after 55h,aah
module rtcpw_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [4:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [4:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // timekeeping sources
    input wire logic sec_clk,
    input wire logic alarm_pulse,
    // board-facing pin and pad control
    output logic clk_out_pin,
    output logic port_input_level_select
);
    import rtcpw_pkg::*;

    logic aw_got_r;
    logic w_got_r;
    logic [4:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic [15:0] clk_cfg_r;
    logic [15:0] alm_cfg_r;
    logic [1:0] pad_r;
    logic clk_out_r;
    logic unlock_open;
    logic open_hold_r;
    logic [1:0] tptr;
    logic [1:0] aptr;
    logic [15:0] twin_rd;
    logic [15:0] awin_rd;

    assign awready = !aw_got_r && !bvalid;
    assign wready = !w_got_r && !bvalid;
    assign arready = !rvalid;

    // write path: both channels captured in either order, then committed
    wire wr_go = aw_got_r && w_got_r && !bvalid;
    wire [4:0] wa = aw_addr_r;
    wire lo_en = w_strb_r[0];
    wire hi_en = w_strb_r[1];
    wire wr_clk = wr_go && wa == rtcpw_off_clk_cfg;
    wire wr_alm = wr_go && wa == rtcpw_off_alm_cfg;
    wire wr_twin = wr_go && wa == rtcpw_off_time_win;
    wire wr_awin = wr_go && wa == rtcpw_off_alm_win;
    wire wr_key = wr_go && wa == rtcpw_off_unlock && lo_en;
    wire wr_pad = wr_go && wa == rtcpw_off_pad_cfg;
    wire wr_map = wr_clk || wr_alm || wr_twin || wr_awin || wr_key || wr_pad ||
                  (wr_go && wa == rtcpw_off_unlock);

    // read path: decode at the address handshake
    wire rd_go = arvalid && arready;
    wire rd_twin = rd_go && araddr == rtcpw_off_time_win;
    wire rd_awin = rd_go && araddr == rtcpw_off_alm_win;
    wire rd_map = araddr == rtcpw_off_clk_cfg || araddr == rtcpw_off_alm_cfg || araddr == rtcpw_off_time_win ||
                  araddr == rtcpw_off_alm_win || araddr == rtcpw_off_unlock || araddr == rtcpw_off_pad_cfg;
    logic [15:0] rd_mux;
    assign rd_mux = (araddr == rtcpw_off_clk_cfg) ? {clk_cfg_r[15:10], tptr, clk_cfg_r[7:0]} :
                    (araddr == rtcpw_off_alm_cfg) ? {alm_cfg_r[15:10], aptr, alm_cfg_r[7:0]} :
                    (araddr == rtcpw_off_time_win) ? twin_rd :
                    (araddr == rtcpw_off_alm_win) ? awin_rd :
                    (araddr == rtcpw_off_pad_cfg) ? {14'h0000, pad_r} : 16'h0000;

    // enable bit may rise only while the unlock is open or held for the next write; clearing is always allowed
    wire wren_now = clk_cfg_r[rtcpw_wren_bit];
    wire wren_new = hi_en ? w_data_r[rtcpw_wren_bit] : wren_now;
    // a bus write needs several cycles, so the one-cycle unlock is held until the next write commits
    wire unlock_eff = unlock_open || open_hold_r;
    wire wren_nxt = (wren_new && !wren_now) ? unlock_eff : wren_new;

    rtcpw_acc_t tacc;
    rtcpw_acc_t aacc;
    // one read handshake is one access whatever the byte lanes asked for
    assign tacc = '{rd: rd_twin, wr_lo: wr_twin && lo_en, wr_hi: wr_twin && hi_en, wdata: w_data_r[15:0]};
    assign aacc = '{rd: rd_awin, wr_lo: wr_awin && lo_en, wr_hi: wr_awin && hi_en, wdata: w_data_r[15:0]};

    rtcpw_unlock u_unlock (
        .aclk(aclk),
        .aresetn(aresetn),
        .key_wr(wr_key),
        .key_data(w_data_r[7:0]),
        .open_o(unlock_open)
    );

    rtcpw_window #(.NPAIR(4)) u_time (
        .aclk(aclk),
        .aresetn(aresetn),
        .ptr_ld(wr_clk && hi_en),
        .ptr_ld_val(w_data_r[9:8]),
        .acc(tacc),
        .wr_allow(wren_now),
        .ptr_o(tptr),
        .rdata_o(twin_rd)
    );

    rtcpw_window #(.NPAIR(4)) u_alarm (
        .aclk(aclk),
        .aresetn(aresetn),
        .ptr_ld(wr_alm && hi_en),
        .ptr_ld_val(w_data_r[9:8]),
        .acc(aacc),
        .wr_allow(1'b1),
        .ptr_o(aptr),
        .rdata_o(awin_rd)
    );

    // the next committed write of any kind uses up the unlock
    always_ff @(posedge aclk) begin
        if (!aresetn) open_hold_r <= 1'b0;
        else if (wr_go) open_hold_r <= 1'b0;
        else if (unlock_open) open_hold_r <= 1'b1;
    end

    // channel capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            aw_addr_r <= 5'h00;
        end else if (awvalid && awready) begin
            aw_got_r <= 1'b1;
            aw_addr_r <= {awaddr[4:2], 2'h0};
        end else if (wr_go) begin
            aw_got_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_got_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end else if (wvalid && wready) begin
            w_got_r <= 1'b1;
            w_data_r <= wdata;
            w_strb_r <= wstrb;
        end else if (wr_go) begin
            w_got_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= rtcpw_axi_okay;
        end else if (wr_go) begin
            bvalid <= 1'b1;
            bresp <= wr_map ? rtcpw_axi_okay : rtcpw_axi_slverr;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= rtcpw_axi_okay;
        end else if (rd_go) begin
            rvalid <= 1'b1;
            rdata <= {16'h0000, rd_mux};
            rresp <= rd_map ? rtcpw_axi_okay : rtcpw_axi_slverr;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // configuration registers; pointer bits live in the windows, halfsec/sync unused here
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_cfg_r <= rtcpw_clk_cfg_rst;
        end else if (wr_clk) begin
            if (lo_en) clk_cfg_r[7:0] <= w_data_r[7:0];
            if (hi_en) clk_cfg_r[15:8] <= {w_data_r[15] & wren_now, 1'b0, wren_nxt, 2'h0,
                                           w_data_r[rtcpw_oe_bit], 2'h0};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) alm_cfg_r <= rtcpw_alm_cfg_rst;
        else if (wr_alm) begin
            if (lo_en) alm_cfg_r[7:0] <= w_data_r[7:0];
            if (hi_en) alm_cfg_r[15:8] <= {w_data_r[15:10], 2'h0};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) pad_r <= rtcpw_pad_cfg_rst;
        else if (wr_pad && lo_en) pad_r <= w_data_r[1:0];
    end

    // pin output registered so it stays glitch free at the board
    wire out_src = pad_r[rtcpw_sel_bit] ? sec_clk : alarm_pulse;
    always_ff @(posedge aclk) begin
        if (!aresetn) clk_out_r <= 1'b0;
        else clk_out_r <= clk_cfg_r[rtcpw_oe_bit] & out_src;
    end
    assign clk_out_pin = clk_out_r;
    assign port_input_level_select = pad_r[rtcpw_ttl_bit];

    sequence wren_try_s;
        wr_clk && hi_en && w_data_r[rtcpw_wren_bit] && !wren_now;
    endsequence
    wren_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wren_try_s and !unlock_eff |=> !clk_cfg_r[rtcpw_wren_bit]) else $error("enable set while locked");
    wren_open_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wren_try_s and unlock_eff |=> clk_cfg_r[rtcpw_wren_bit]) else $error("enable not set in unlock cycle");
    pin_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !clk_cfg_r[rtcpw_oe_bit] |=> !clk_out_pin) else $error("pin driven with output disabled");
    pin_src_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_cfg_r[rtcpw_oe_bit] |=> clk_out_pin == $past(out_src)) else $error("wrong pin source");
    rd_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_awin && !wr_alm && aptr != 2'h0 |=> aptr == $past(aptr) - 2'h1) else $error("alarm read did not step");
    trd_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_twin && !wr_clk && tptr != 2'h0 |=> tptr == $past(tptr) - 2'h1) else $error("time read did not step");
endmodule : rtcpw_top
`default_nettype wire

/* File: tb/tb_rtcpw_top.sv */
// self-checking testbench for the calendar register window front end
`timescale 1ns/1ns
`default_nettype none
module tb_rtcpw_top;
    import rtcpw_pkg::*;
    typedef struct {logic [4:0] a; logic [15:0] d; logic [3:0] s; logic [15:0] e; logic [1:0] r;} rtcpw_row_t;
    typedef logic [15:0] rtcpw_five_t [5];
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic sec_clk = 1'b0;
    logic alarm_pulse = 1'b0;
    logic [4:0] awaddr = 5'h00;
    logic [4:0] araddr = 5'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, clk_out_pin, port_input_level_select;
    logic [31:0] rdata;
    logic [1:0] bresp, rresp, rsp;
    logic [15:0] rd;
    int error_cnt = 0;
    int checked = 0;
    // strobe 0 rows only read back the reset value
    rtcpw_row_t rows [9] = '{
        '{rtcpw_off_pad_cfg, 16'h0000, 4'h0, 16'h0000, rtcpw_axi_okay},
        '{rtcpw_off_alm_cfg, 16'h0000, 4'h0, 16'h0000, rtcpw_axi_okay},
        '{rtcpw_off_clk_cfg, 16'h0000, 4'h0, 16'h0000, rtcpw_axi_okay},
        '{rtcpw_off_pad_cfg, 16'hffff, 4'hf, 16'h0003, rtcpw_axi_okay},
        '{rtcpw_off_pad_cfg, 16'h0000, 4'h3, 16'h0000, rtcpw_axi_okay},
        '{rtcpw_off_alm_cfg, 16'h00a5, 4'h1, 16'h00a5, rtcpw_axi_okay},
        '{rtcpw_off_clk_cfg, 16'h005a, 4'h1, 16'h005a, rtcpw_axi_okay},
        '{rtcpw_off_clk_cfg, 16'h2000, 4'h2, 16'h005a, rtcpw_axi_okay},
        '{5'h18, 16'h1234, 4'h3, 16'h0000, rtcpw_axi_slverr}};

    rtcpw_top i_dut (
        .aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(1'b1), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(1'b1), .rdata(rdata), .rresp(rresp),
        .sec_clk(sec_clk), .alarm_pulse(alarm_pulse),
        .clk_out_pin(clk_out_pin), .port_input_level_select(port_input_level_select)
    );

    always #50 aclk = ~aclk;

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // bready stays high, so the response is taken at the edge bvalid is seen
    task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic [3:0] s);
        int n;
        n = 0;
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= {16'h0000, d};
        wstrb <= s;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        rsp = bresp;
        if (n >= 50) error_cnt++;
    endtask : wr

    task automatic rd_(input logic [4:0] a);
        int n;
        n = 0;
        arvalid <= 1'b1;
        araddr <= a;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        rd = rdata[15:0];
        rsp = rresp;
        if (n >= 50) error_cnt++;
    endtask : rd_

    // loads pointer 3, then reads the window five times; the first three reads each step the pointer once, the last two leave it at zero
    task automatic sweep(input logic [4:0] ca, input logic [4:0] wa, input logic [15:0] cfg, input rtcpw_five_t e);
        wr(ca, cfg, 4'h3);
        for (int i = 0; i < 5; i++) begin
            rd_(wa);
            chk("window data", e[i], rd);
            rd_(ca);
            chk("window pointer", (i < 2) ? 16'(2 - i) : 16'h0000, {14'h0, rd[9:8]});
        end
    endtask : sweep

    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        final_report();
    end

    initial begin
        rtcpw_five_t vals;
        vals = '{16'h0c1f, 16'h0317, 16'h1e00, 16'h2d3b, 16'h0000};
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d, rows[i].s);
            chk("bresp", {14'h0, rows[i].r}, {14'h0, rsp});
            rd_(rows[i].a);
            chk("rresp", {14'h0, rows[i].r}, {14'h0, rsp});
            chk("readback", rows[i].e, rd);
        end
        // alarm window: pointer 2 down to 0, the last write lands on pair 0 again
        wr(rtcpw_off_alm_cfg, 16'h02a5, 4'h3);
        for (int i = 0; i < 4; i++) begin
            wr(rtcpw_off_alm_win, vals[i], 4'h3);
            rd_(rtcpw_off_alm_cfg);
            chk("alarm pointer", (i < 2) ? 16'(1 - i) : 16'h0000, {14'h0, rd[9:8]});
        end
        wr(rtcpw_off_alm_win, 16'h0005, 4'h1);
        sweep(rtcpw_off_alm_cfg, rtcpw_off_alm_win, 16'h03a5, '{16'h0000, 16'h0c1f, 16'h0317, 16'h2d05, 16'h2d05});
        // time window while locked: data dropped, high-byte write still steps
        wr(rtcpw_off_clk_cfg, 16'h035a, 4'h3);
        wr(rtcpw_off_time_win, 16'hffff, 4'h3);
        wr(rtcpw_off_time_win, 16'hffff, 4'h1);
        rd_(rtcpw_off_clk_cfg);
        chk("time pointer", 16'h0002, {14'h0, rd[9:8]});
        sweep(rtcpw_off_clk_cfg, rtcpw_off_time_win, 16'h035a, '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000});
        // unlock, then set the value-write enable straight away
        wr(rtcpw_off_unlock, {8'h00, rtcpw_key_first}, 4'h1);
        wr(rtcpw_off_unlock, {8'h00, rtcpw_key_second}, 4'h1);
        wr(rtcpw_off_clk_cfg, 16'h235a, 4'h3);
        rd_(rtcpw_off_clk_cfg);
        chk("write enable", 16'h0001, {15'h0, rd[rtcpw_wren_bit]});
        vals = '{16'hff24, 16'h0c1f, 16'h0317, 16'h2d3b, 16'h0000};
        for (int i = 0; i < 4; i++) begin
            wr(rtcpw_off_time_win, vals[i], 4'h3);
        end
        sweep(rtcpw_off_clk_cfg, rtcpw_off_time_win, 16'h235a, '{16'h0024, 16'h0c1f, 16'h0317, 16'h2d3b, 16'h2d3b});
        // output pin: every mix of level select, source select, enable and both sources
        for (int k = 0; k < 32; k++) begin
            wr(rtcpw_off_pad_cfg, {14'h0, k[1], k[0]}, 4'h1);
            wr(rtcpw_off_clk_cfg, {5'h00, k[2], 10'h000}, 4'h3);
            sec_clk <= k[3];
            alarm_pulse <= k[4];
            repeat (3) @(posedge aclk);
            chk("clock out pin", {15'h0, k[2] & (k[1] ? k[3] : k[4])}, {15'h0, clk_out_pin});
            chk("level select", {15'h0, k[0]}, {15'h0, port_input_level_select});
        end
        // second reset in mid-run with the pin driven high
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("pin after reset", 16'h0000, {15'h0, clk_out_pin});
        rd_(rtcpw_off_clk_cfg);
        chk("config after reset", rtcpw_clk_cfg_rst, rd);
        rd_(rtcpw_off_alm_cfg);
        chk("alarm config after reset", rtcpw_alm_cfg_rst, rd);
        final_report();
    end
endmodule : tb_rtcpw_top
`default_nettype wire
